// ---- rtl/fcr_consts.svh ----
// register offsets, field positions and timing constants for the flash controller
`ifndef FCR_CONSTS_SVH
`define FCR_CONSTS_SVH
`define FCR_FLASH_BASE      32'h0010_0000
`define FCR_SRAM_BASE       32'h0020_0000
`define FCR_ZERO_BASE       32'h0000_0000
`define FCR_AREA_MASK       32'hFFF0_0000
`define FCR_PAGES           1024
`define FCR_PAGE_BYTES      256
`define FCR_PAGE_WORDS      64
`define FCR_FLASH_WORDS     65536
`define FCR_SRAM_WORDS      16384
`define FCR_REGIONS         16
`define FCR_REGION_SHIFT    6
`define FCR_REG_MODE        12'h000
`define FCR_REG_CMD         12'h004
`define FCR_REG_STATUS      12'h008
`define FCR_REG_NVM         12'h00C
`define FCR_REG_REMAP       12'h010
`define FCR_MODE_WS_LSB     0
`define FCR_MODE_IE_END     4
`define FCR_MODE_IE_ERR     5
`define FCR_ST_READY        0
`define FCR_ST_LOCKERR      1
`define FCR_ST_BUSYERR      2
`define FCR_ST_SECERR       3
`define FCR_CMD_ARG_LSB     8
`define FCR_CMD_ARG_MSB     17
`define FCR_PROG_ERASE_MS   4
`define FCR_PROG_ONLY_MS    2
`define FCR_FULL_ERASE_MS   10
`define FCR_CLK_MHZ         125
`define FCR_CYC_PER_MS      (`FCR_CLK_MHZ * 1000)
`define FCR_MAX_WS          3
`endif

// ---- rtl/fcr_flash_ctrl.sv ----
// flash controller, write buffer, prefetch, lock/security bits and remap decode
// Behaviour
// RULE_01: sram only at fixed base before remap
// RULE_02: after remap sram also at zero
// RULE_03: flash at base, at zero before remap
// RULE_04: 1024 pages of 256 bytes, words
// RULE_05: 256-byte page buffer filled by words
// RULE_06: flash standby when no access
// RULE_07: software sets waits, commands, reads status
// RULE_08: dual word prefetch serves halfword fetches
// RULE_09: sixteen lock bits, 64 pages each
// RULE_10: locked erase or program aborts, interrupts
// RULE_11: set-lock protects, clear-lock unprotects region
// RULE_12: erase pin clears all lock bits
// RULE_13: security blocks debug and fast port
// RULE_14: security set by command, cleared by erase
// RULE_15: erase pin held over 50 ms; the design acts on the pin level in any single cycle
// RULE_16: nv bit 0 enables brownout detector
// RULE_17: nv bit 1 enables brownout reset
// RULE_18: nv bits changed only by commands; the erase pin also clears both gpnv bits
// RULE_19: eight calibration bits fixed, erase-proof
// RULE_20: fast port enabled by test straps
// RULE_21: fast port accepts all flash commands
// RULE_22: program 4 or 2 ms, erase 10 ms
// RULE_23: up to three read wait states
// RULE_24: command while busy refused, flagged
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "fcr_consts.svh"
module fcr_flash_ctrl
    import fcr_pkg::*;
#(
    parameter int unsigned PROG_ERASE_CYC = `FCR_PROG_ERASE_MS * `FCR_CYC_PER_MS,
    parameter int unsigned PROG_CYC       = `FCR_PROG_ONLY_MS * `FCR_CYC_PER_MS,
    parameter int unsigned FULL_ERASE_CYC = `FCR_FULL_ERASE_MS * `FCR_CYC_PER_MS,
    parameter logic [7:0]  CALIB_VALUE    = 8'hA5  // arbitrary value
) (
    // clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_sys_rst,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       o_prdata,
    output logic              o_pready,
    output logic              o_pslverr,
    // memory port from bus masters and fast programming port
    input  wire fcr_mem_req_t i_mem_req,
    output fcr_mem_rsp_t      o_mem_rsp,
    // pins and straps
    input  wire logic         i_erase_pin,
    input  wire logic         i_test_mode_pin,
    input  wire logic         i_port_a_line_zero,
    input  wire logic         i_port_a_line_one,
    input  wire logic         i_port_a_line_two,
    // status outputs
    output logic              o_irq,
    output logic              o_flash_standby,
    output logic              o_brownout_detector_en,
    output logic              o_brownout_reset_en,
    output logic [7:0]        o_calib,
    output logic              o_fast_programming_port_en
);
    // storage
    logic [31:0] flash_mem [`FCR_FLASH_WORDS];
    logic [31:0] sram_mem  [`FCR_SRAM_WORDS];
    logic [31:0] page_buf  [`FCR_PAGE_WORDS];

    // control state
    fcr_state_t  state_q, state_d;
    fcr_cmd_t    cmd_q, cmd_d;
    logic [9:0]  page_q, page_d;
    logic [23:0] timer_q, timer_d;
    logic [6:0]  wipe_q, wipe_d;
    logic [1:0]  ws_q, ws_d;
    logic        ie_end_q, ie_end_d, ie_err_q, ie_err_d;
    logic        ready_q, ready_d, lockerr_q, lockerr_d;
    logic        busyerr_q, busyerr_d, secerr_q, secerr_d;
    logic [15:0] lock_q, lock_d;
    logic        sec_q, sec_d;
    logic [1:0]  gpnv_q, gpnv_d;
    logic        remap_q, remap_d;
    logic        erased_q, erased_d;
    // read path
    logic [1:0]  wait_q, wait_d;
    logic        rvalid_q, rvalid_d, rerr_q, rerr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] pf_tag_q [2];
    logic [31:0] pf_dat_q [2];
    logic        pf_val_q [2];
    logic        pf_fill;
    logic [15:0] pf_tag_d;
    // apb
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d;

    // address decode
    logic        area_flash, area_sram, hit_zero, to_flash, to_sram, sec_block;
    logic        apb_wr, apb_acc, cmd_issue, fast_en;
    logic [15:0] fl_word;
    logic [13:0] sr_word;
    logic [15:0] line;
    logic [1:0]  pf_hit;
    fcr_cmd_t    new_cmd;
    logic [9:0]  new_arg;
    logic        is_prog_erase;

    assign hit_zero   = (i_mem_req.addr & `FCR_AREA_MASK) == `FCR_ZERO_BASE;
    assign area_flash = (i_mem_req.addr & `FCR_AREA_MASK) == `FCR_FLASH_BASE;
    assign area_sram  = (i_mem_req.addr & `FCR_AREA_MASK) == `FCR_SRAM_BASE;
    assign to_flash   = area_flash || (hit_zero && !remap_q); // RULE_03
    assign to_sram    = area_sram || (hit_zero && remap_q); // RULE_01 RULE_02
    assign fl_word    = i_mem_req.addr[17:2]; // RULE_04
    assign sr_word    = i_mem_req.addr[15:2];
    assign line       = fl_word;
    assign fast_en    = i_test_mode_pin && i_port_a_line_zero && i_port_a_line_one
                        && !i_port_a_line_two; // RULE_20
    assign sec_block  = sec_q && (i_mem_req.debug_port || i_mem_req.fast_port); // RULE_13
    assign apb_acc    = psel && penable;
    assign apb_wr     = apb_acc && pwrite;
    assign cmd_issue  = apb_wr && paddr == `FCR_REG_CMD;
    assign new_cmd    = fcr_cmd_t'(pwdata[3:0]);
    assign new_arg    = pwdata[`FCR_CMD_ARG_MSB:`FCR_CMD_ARG_LSB];
    assign is_prog_erase = cmd_q == FCR_CMD_PROG_ERASE || cmd_q == FCR_CMD_PROG
                           || cmd_q == FCR_CMD_PAGE_ERASE;

    // prefetch: even and odd word buffers, both matched on the word pair, so one tag also serves the other word of its pair
    for (genvar g = 0; g < 2; g++) begin : g_pf
        assign pf_hit[g] = pf_val_q[g] && pf_tag_q[g] == {line[15:1], 1'(g)}; // RULE_08
        always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                pf_val_q[g] <= 1'b0;
                pf_tag_q[g] <= 16'h0000;
                pf_dat_q[g] <= 32'h0000_0000;
            end else if (state_q == FCR_BUSY) begin
                pf_val_q[g] <= 1'b0;   // contents may change under a command
            end else if (pf_fill && pf_tag_d[0] == 1'(g)) begin
                pf_val_q[g] <= 1'b1;
                pf_tag_q[g] <= pf_tag_d;
                pf_dat_q[g] <= flash_mem[pf_tag_d];
            end
        end
    end

    // memory access path
    always_comb begin
        wait_d   = wait_q;
        rvalid_d = 1'b0;
        rerr_d   = 1'b0;
        rdata_d  = rdata_q;
        pf_fill  = 1'b0;
        pf_tag_d = line;
        if (i_mem_req.valid && !rvalid_q) begin
            if (sec_block || !(to_flash || to_sram) || (to_flash && state_q == FCR_BUSY)) begin
                rvalid_d = 1'b1;
                rerr_d   = 1'b1;
            end else if (to_sram || i_mem_req.write) begin
                rvalid_d = 1'b1;
                rdata_d  = to_sram ? sram_mem[sr_word] : 32'h0000_0000;
            end else if (|pf_hit) begin
                rvalid_d = 1'b1;
                rdata_d  = pf_hit[0] ? pf_dat_q[0] : pf_dat_q[1];
            end else if (wait_q == ws_q) begin // RULE_23
                rvalid_d = 1'b1;
                rdata_d  = flash_mem[fl_word];
                pf_fill  = 1'b1;
                wait_d   = 2'b00;
            end else begin
                wait_d   = wait_q + 2'b01;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_mem_req.valid && i_mem_req.write && !rvalid_q && !sec_block) begin
            if (to_sram) begin
                sram_mem[sr_word] <= i_mem_req.wdata;
            end else if (to_flash && state_q == FCR_IDLE) begin
                page_buf[fl_word[5:0]] <= i_mem_req.wdata; // RULE_05
            end
        end
        if (state_q == FCR_BUSY && timer_q == 24'h000001) begin
            if (cmd_q == FCR_CMD_FULL_ERASE) begin
                for (int w = 0; w < `FCR_FLASH_WORDS; w++) begin
                    flash_mem[w] <= 32'hFFFF_FFFF;
                end
            end else if (is_prog_erase) begin
                for (int w = 0; w < `FCR_PAGE_WORDS; w++) begin
                    flash_mem[{page_q, 6'(w)}] <= (cmd_q == FCR_CMD_PAGE_ERASE)
                        ? 32'hFFFF_FFFF
                        : (cmd_q == FCR_CMD_PROG ? flash_mem[{page_q, 6'(w)}] & page_buf[w]
                                                 : page_buf[w]);
                end
            end
        end
    end

    // command sequencer and non-volatile bits
    always_comb begin
        state_d   = state_q;
        cmd_d     = cmd_q;
        page_d    = page_q;
        timer_d   = timer_q;
        ready_d   = ready_q;
        lockerr_d = lockerr_q;
        busyerr_d = busyerr_q;
        secerr_d  = secerr_q;
        lock_d    = lock_q;
        sec_d     = sec_q;
        gpnv_d    = gpnv_q;
        erased_d  = erased_q;
        if (apb_acc && !pwrite && paddr == `FCR_REG_STATUS) begin
            lockerr_d = 1'b0;
            busyerr_d = 1'b0;
            secerr_d  = 1'b0;
        end
        case (state_q)
            FCR_IDLE: begin
                if (cmd_issue) begin
                    ready_d = 1'b0;
                    cmd_d   = new_cmd;
                    page_d  = new_arg;
                    state_d = FCR_BUSY;
                    timer_d = 24'h000001;
                    if ((new_cmd == FCR_CMD_PROG_ERASE || new_cmd == FCR_CMD_PROG
                         || new_cmd == FCR_CMD_PAGE_ERASE)
                        && lock_q[new_arg[9:`FCR_REGION_SHIFT]]) begin // RULE_09
                        lockerr_d = 1'b1; // RULE_10
                        cmd_d     = FCR_CMD_NONE;
                    end else if (new_cmd == FCR_CMD_PROG_ERASE) begin
                        timer_d = 24'(PROG_ERASE_CYC); // RULE_22
                    end else if (new_cmd == FCR_CMD_PROG || new_cmd == FCR_CMD_PAGE_ERASE) begin
                        timer_d = 24'(PROG_CYC);
                    end else if (new_cmd == FCR_CMD_FULL_ERASE) begin
                        timer_d = 24'(FULL_ERASE_CYC);
                    end
                    if (i_mem_req.fast_port && sec_q) begin
                        secerr_d = 1'b1;
                    end
                end
            end
            FCR_BUSY: begin
                if (cmd_issue) begin
                    busyerr_d = 1'b1; // RULE_24
                end
                timer_d = timer_q - 24'h000001;
                if (timer_q == 24'h000001) begin
                    state_d = FCR_IDLE;
                    ready_d = 1'b1;
                    case (cmd_q)
                        FCR_CMD_SET_LOCK:   lock_d[page_q[3:0]] = 1'b1; // RULE_11
                        FCR_CMD_CLR_LOCK:   lock_d[page_q[3:0]] = 1'b0; // RULE_11
                        FCR_CMD_SET_SEC:    sec_d = 1'b1; // RULE_14
                        FCR_CMD_SET_GPNV:   gpnv_d[page_q[0]] = 1'b1; // RULE_18
                        FCR_CMD_CLR_GPNV:   gpnv_d[page_q[0]] = 1'b0; // RULE_18
                        FCR_CMD_FULL_ERASE: begin
                            if (erased_q) begin
                                sec_d = 1'b0; // RULE_14
                            end
                            erased_d = 1'b0;
                        end
                        default: ;
                    endcase
                end
            end
            default: state_d = FCR_IDLE;
        endcase
        // erase pin arms security removal for the next full erase
        if (i_erase_pin) begin
            lock_d   = 16'h0000; // RULE_12
            gpnv_d   = 2'b00; // RULE_16 RULE_17
            erased_d = 1'b1;
        end
    end

    // register access
    always_comb begin
        prdata_d  = 32'h0000_0000;
        pready_d  = psel && !penable;
        pslverr_d = 1'b0;
        ws_d      = ws_q;
        ie_end_d  = ie_end_q;
        ie_err_d  = ie_err_q;
        remap_d   = remap_q;
        if (psel && !penable) begin
            case (paddr)
                `FCR_REG_MODE:   prdata_d = {26'h0, ie_err_q, ie_end_q, 2'b00, ws_q};
                `FCR_REG_CMD:    prdata_d = {14'h0, page_q, 4'h0, 4'(cmd_q)};
                `FCR_REG_STATUS: prdata_d = {28'h0, secerr_q, busyerr_q, lockerr_q, ready_q};
                `FCR_REG_NVM:    prdata_d = {5'h0, sec_q, gpnv_q, lock_q, CALIB_VALUE};
                `FCR_REG_REMAP:  prdata_d = {31'h0, remap_q};
                default:         pslverr_d = 1'b1;
            endcase
        end
        if (apb_wr && paddr == `FCR_REG_MODE) begin // RULE_07
            ws_d     = pwdata[`FCR_MODE_WS_LSB +: 2];
            ie_end_d = pwdata[`FCR_MODE_IE_END];
            ie_err_d = pwdata[`FCR_MODE_IE_ERR];
        end
        if (apb_wr && paddr == `FCR_REG_REMAP && pwdata[0]) begin
            remap_d = 1'b1; // RULE_02
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q   <= FCR_IDLE;
            cmd_q     <= FCR_CMD_NONE;
            page_q    <= 10'h000;
            timer_q   <= 24'h000000;
            ready_q   <= 1'b1;
            lockerr_q <= 1'b0;
            busyerr_q <= 1'b0;
            secerr_q  <= 1'b0;
            erased_q  <= 1'b0;
            ws_q      <= 2'b00;
            ie_end_q  <= 1'b0;
            ie_err_q  <= 1'b0;
            remap_q   <= 1'b0; // RULE_01
            wait_q    <= 2'b00;
            rvalid_q  <= 1'b0;
            rerr_q    <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_irq     <= 1'b0;
            o_flash_standby <= 1'b1;
            o_fast_programming_port_en <= 1'b0;
            o_calib   <= 8'h00;
        end else begin
            state_q   <= state_d;
            cmd_q     <= cmd_d;
            page_q    <= page_d;
            timer_q   <= timer_d;
            ready_q   <= ready_d;
            lockerr_q <= lockerr_d;
            busyerr_q <= busyerr_d;
            secerr_q  <= secerr_d;
            erased_q  <= erased_d;
            ws_q      <= ws_d;
            ie_end_q  <= ie_end_d;
            ie_err_q  <= ie_err_d;
            remap_q   <= remap_d;
            wait_q    <= wait_d;
            rvalid_q  <= rvalid_d;
            rerr_q    <= rerr_d;
            rdata_q   <= rdata_d;
            o_prdata  <= prdata_d;
            o_pready  <= pready_d;
            o_pslverr <= pslverr_d;
            o_irq     <= (ie_end_q && ready_q) || (ie_err_q && (lockerr_q || busyerr_q
                         || secerr_q)); // RULE_10
            o_flash_standby <= !(i_mem_req.valid && to_flash) && state_q == FCR_IDLE; // RULE_06
            o_fast_programming_port_en <= fast_en; // RULE_20 RULE_21
            o_calib   <= CALIB_VALUE; // RULE_19
        end
    end

    // non-volatile bits are not touched by system reset; they model cell contents
    always_ff @(posedge i_core_clk) begin
        lock_q <= lock_d;
        sec_q  <= sec_d;
        gpnv_q <= gpnv_d;
        o_brownout_detector_en <= gpnv_d[0]; // RULE_16
        o_brownout_reset_en    <= gpnv_d[1]; // RULE_17
    end

    assign o_mem_rsp = '{valid: rvalid_q, error: rerr_q, rdata: rdata_q};
endmodule

// ---- rtl/fcr_pkg.sv ----
// types for the flash controller and remap decode
package fcr_pkg;
    typedef enum logic [3:0] {
        FCR_CMD_NONE, FCR_CMD_PROG_ERASE, FCR_CMD_PROG, FCR_CMD_PAGE_ERASE,
        FCR_CMD_FULL_ERASE, FCR_CMD_SET_LOCK, FCR_CMD_CLR_LOCK, FCR_CMD_SET_SEC,
        FCR_CMD_SET_GPNV, FCR_CMD_CLR_GPNV
    } fcr_cmd_t;
    typedef enum logic [1:0] {FCR_IDLE, FCR_BUSY} fcr_state_t;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        fast_port;
        logic        debug_port;
    } fcr_mem_req_t;
    typedef struct packed {
        logic        valid;
        logic        error;
        logic [31:0] rdata;
    } fcr_mem_rsp_t;
endpackage

// ---- tb/fcr_bus_master.sv ----
// bus master model: one outstanding word access, optional stall before it
`timescale 1ns/1ps
module fcr_bus_master
    import fcr_pkg::*;
(
    input  wire logic         i_core_clk,
    output fcr_mem_req_t      o_req,
    input  wire fcr_mem_rsp_t i_rsp
);
    initial o_req = '0;
    task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d,
                          input logic fp, input logic dp, input int gap,
                          output logic [31:0] rd, output logic er);
        repeat (gap + 1) @(posedge i_core_clk);
        o_req <= '{1'b1, w, a, d, fp, dp};
        do @(posedge i_core_clk); while (i_rsp.valid !== 1'b1);
        rd = i_rsp.rdata;
        er = i_rsp.error;
        // released lines show the inverse so stale values never look valid
        o_req <= '{1'b0, 1'b0, ~a, ~d, 1'b0, 1'b0};
    endtask
endmodule

// ---- tb/fcr_properties.sv ----
// port checks for the flash controller
`timescale 1ns/1ps
module fcr_properties
    import fcr_pkg::*;
#(
    parameter logic [7:0] CALIB_VALUE = 8'hA5  // arbitrary value
) (
    // clock and reset
    input wire logic         i_core_clk,
    input wire logic         i_sys_rst,
    // apb
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         o_pready,
    // memory port
    input wire fcr_mem_req_t i_mem_req,
    input wire fcr_mem_rsp_t o_mem_rsp,
    // pins and status
    input wire logic         i_erase_pin,
    input wire logic         i_test_mode_pin,
    input wire logic         i_port_a_line_zero,
    input wire logic         i_port_a_line_one,
    input wire logic         i_port_a_line_two,
    input wire logic         o_brownout_detector_en,
    input wire logic         o_brownout_reset_en,
    input wire logic [7:0]   o_calib,
    input wire logic         o_fast_programming_port_en
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    sequence apb_setup_s; psel && !penable; endsequence
    sequence apb_done_s; psel && penable && o_pready; endsequence
    sequence mem_start_s; $rose(i_mem_req.valid); endsequence

    apb_answer_a: assert property (apb_setup_s |=> apb_done_s)
        else $error("apb access phase without ready");
    ready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("ready held past one cycle");
    mem_answer_a: assert property (mem_start_s |-> ##[1:4] o_mem_rsp.valid)
        else $error("memory answer beyond three wait states");
    rsp_pulse_a: assert property (o_mem_rsp.valid |=> !o_mem_rsp.valid)
        else $error("memory answer held too long");
    abort_area_a: assert property (
        o_mem_rsp.valid && $past(i_mem_req.addr[31:20]) > 12'h002 |-> o_mem_rsp.error)
        else $error("undefined area answered without error");
    fast_entry_a: assert property (!$past(i_sys_rst) |->
        o_fast_programming_port_en == $past(i_test_mode_pin && i_port_a_line_zero
        && i_port_a_line_one && !i_port_a_line_two))
        else $error("fast port enable wrong for straps");
    calib_fixed_a: assert property (!$past(i_sys_rst) |-> o_calib == CALIB_VALUE)
        else $error("calibration bits changed");
    erase_nv_a: assert property ($rose(i_erase_pin) |-> ##[1:3]
        (!o_brownout_detector_en && !o_brownout_reset_en))
        else $error("erase pin left a nv bit set");
endmodule

bind fcr_flash_ctrl fcr_properties #(.CALIB_VALUE(CALIB_VALUE)) i_props (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .psel(psel), .penable(penable),
    .o_pready(o_pready), .i_mem_req(i_mem_req), .o_mem_rsp(o_mem_rsp),
    .i_erase_pin(i_erase_pin), .i_test_mode_pin(i_test_mode_pin),
    .i_port_a_line_zero(i_port_a_line_zero), .i_port_a_line_one(i_port_a_line_one),
    .i_port_a_line_two(i_port_a_line_two), .o_brownout_detector_en(o_brownout_detector_en),
    .o_brownout_reset_en(o_brownout_reset_en), .o_calib(o_calib),
    .o_fast_programming_port_en(o_fast_programming_port_en));

// ---- tb/tb_embedded_flash_ctrl_remap.sv ----
// self-checking bench for the flash controller and remap decode
`timescale 1ns/1ps
`include "fcr_consts.svh"
module tb_embedded_flash_ctrl_remap;
    import fcr_pkg::*;
    localparam int          PE    = 20;
    localparam int          PO    = 10;
    localparam int          FE    = 40;
    localparam logic [7:0]  CALIB = 8'h3C;  // arbitrary value
    localparam logic [31:0] FB    = `FCR_FLASH_BASE;
    localparam logic [31:0] SB    = `FCR_SRAM_BASE;
    logic         i_core_clk = 1'b0;
    logic         i_sys_rst  = 1'b1;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, erase = 1'b1;
    logic [11:0]  paddr  = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic [3:0]   straps = 4'h0;
    logic [31:0]  o_prdata, rdat, mrd, sv, pg [64];
    logic [31:0]  flm [int];
    logic [31:0]  seed = 32'hE24F0949;
    logic [7:0]   o_calib;
    logic         o_pready, o_pslverr, o_irq, o_sb, o_bod, o_bor, o_fpp, rerr, merr, irq_s, sb_s;
    fcr_mem_req_t mreq;
    fcr_mem_rsp_t mrsp;
    int           error_cnt = 0, comparisons = 0, cyc = 0;

    always #4 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) cyc <= cyc + 1;

    fcr_flash_ctrl #(.PROG_ERASE_CYC(PE), .PROG_CYC(PO), .FULL_ERASE_CYC(FE),
        .CALIB_VALUE(CALIB)) i_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_mem_req(mreq), .o_mem_rsp(mrsp), .i_erase_pin(erase),
        .i_test_mode_pin(straps[3]), .i_port_a_line_zero(straps[2]),
        .i_port_a_line_one(straps[1]), .i_port_a_line_two(straps[0]), .o_irq(o_irq),
        .o_flash_standby(o_sb), .o_brownout_detector_en(o_bod),
        .o_brownout_reset_en(o_bor), .o_calib(o_calib), .o_fast_programming_port_en(o_fpp));
    fcr_bus_master i_master (.i_core_clk(i_core_clk), .o_req(mreq), .i_rsp(mrsp));

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
        return seed;
    endfunction
    function automatic logic [31:0] cmd_word(input int code, input int arg);
        return {14'h0, arg[9:0], 4'h0, code[3:0]};
    endfunction
    task automatic conclude();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge i_core_clk);
        penable <= 1'b1;
        do @(posedge i_core_clk); while (o_pready !== 1'b1);
        rdat = o_prdata;
        rerr = o_pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic mem(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [1:0] pd);
        i_master.access(w, a, d, pd[1], pd[0], int'(rnd() & 32'h3), mrd, merr);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] pd,
                         input logic eexp);
        mem(1'b0, a, 32'h0, pd);
        chk(merr, eexp);
        if (!eexp) chk(mrd, exp);
    endtask
    task automatic fill();
        for (int i = 0; i < 64; i++) begin
            pg[i] = rnd();
            mem(1'b1, FB + 32'(i * 4), pg[i], 2'b00);
            chk(merr, 0);
        end
    endtask
    task automatic wait_rdy(input int t0, input int t_exp);
        do apb(1'b0, `FCR_REG_STATUS, 32'h0); while (rdat[0] !== 1'b1);
        if (t_exp > 0) chk(32'(cyc - t0 >= t_exp - 2 && cyc - t0 <= t_exp + 10), 1);
    endtask
    task automatic run(input int code, input int arg, input int t_exp);
        int t0;
        apb(1'b1, `FCR_REG_CMD, cmd_word(code, arg));
        t0 = cyc;
        repeat (2) @(posedge i_core_clk);
        irq_s = o_irq;
        sb_s = o_sb;
        wait_rdy(t0, t_exp);
    endtask

    initial begin
        repeat (60000) @(posedge i_core_clk);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        repeat (5) @(posedge i_core_clk);
        erase <= 1'b0;
        // security cell starts unknown: pin plus full erase defines it
        run(4, 0, FE);
        chk(o_sb, 1);
        apb(1'b0, `FCR_REG_NVM, 32'h0);
        chk(rdat, {24'h0, CALIB});
        apb(1'b0, `FCR_REG_STATUS, 32'h0);
        chk(rdat, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk(rerr, 1);
        for (int i = 0; i < 16; i++) begin
            straps <= i[3:0];
            repeat (2) @(posedge i_core_clk);
            chk(o_fpp, i == 14);
        end
        straps <= 4'h0;
        apb(1'b1, `FCR_REG_MODE, 32'h3);
        fill();
        run(1, 0, PE);
        chk(sb_s, 0);
        for (int i = 0; i < 64; i++) flm[i] = pg[i];
        rdchk(32'h0, flm[0], 2'b00, 1'b0);
        rdchk(FB + 32'hFC, flm[63], 2'b00, 1'b0);
        // a second command and a flash read while programming are both refused
        apb(1'b1, `FCR_REG_CMD, cmd_word(1, 5));
        apb(1'b1, `FCR_REG_CMD, cmd_word(8, 0));
        apb(1'b0, `FCR_REG_STATUS, 32'h0);
        chk(rdat, 32'h4);
        rdchk(FB, 0, 2'b00, 1'b1);
        wait_rdy(cyc, 0);
        chk(o_bod, 0);
        run(8, 0, 0);
        run(8, 1, 0);
        run(9, 0, 0);
        chk({o_bor, o_bod}, 2'b10);
        run(5, 1, 0);
        run(1, 64, 0);
        chk(rdat, 32'h3);
        chk(irq_s, 0);
        apb(1'b1, `FCR_REG_MODE, 32'h23);
        run(1, 64, 0);
        chk(irq_s, 1);
        repeat (2) @(posedge i_core_clk);
        chk(o_irq, 0);
        run(1, 63, PE);
        chk(rdat, 32'h1);
        run(5, 0, 0);
        fill();
        run(2, 0, 0);
        chk(rdat, 32'h3);
        rdchk(FB, flm[0], 2'b00, 1'b0);
        run(6, 0, 0);
        run(2, 0, PO);
        chk(rdat, 32'h1);
        for (int i = 0; i < 64; i++) flm[i] = flm[i] & pg[i];
        rdchk(FB + 32'h4, flm[1], 2'b00, 1'b0);
        sv = rnd();
        mem(1'b1, SB + 32'h10, sv, 2'b00);
        rdchk(32'h10, flm[4], 2'b00, 1'b0);
        rdchk(SB + 32'h10, sv, 2'b00, 1'b0);
        apb(1'b1, `FCR_REG_REMAP, 32'h1);
        rdchk(32'h10, sv, 2'b00, 1'b0);
        rdchk(FB + 32'h10, flm[4], 2'b00, 1'b0);
        rdchk(32'h0030_0000, 0, 2'b00, 1'b1);
        run(6, 1, 0);
        run(4, 0, FE);
        run(7, 0, 0);
        rdchk(FB, 0, 2'b01, 1'b1);
        rdchk(FB, 0, 2'b10, 1'b1);
        mem(1'b0, FB, 32'h0, 2'b00);
        chk(merr, 0);
        run(4, 0, FE);
        apb(1'b0, `FCR_REG_NVM, 32'h0);
        chk(rdat[26], 1);
        // pin hold shortened: the design samples its level only
        erase <= 1'b1;
        repeat (10) @(posedge i_core_clk);
        erase <= 1'b0;
        run(4, 0, FE);
        apb(1'b0, `FCR_REG_NVM, 32'h0);
        chk(rdat, {24'h0, CALIB});
        mem(1'b0, FB, 32'h0, 2'b10);
        chk(merr, 0);
        conclude();
    end
endmodule
